/* File: framer_model.sv */
// framer model: transmit words and frame search control
`timescale 1ns/1ps
`default_nettype none
module framer_model (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic tx_byte_clock_in,
	input wire logic frame_found_pulse_in,
	input wire logic search_req_in,
	output logic [7:0] tx_byte_out,
	output logic frame_search_enable_out
);
	logic clk_prev_reg;
	logic locked_reg;
	// words change just after the byte clock rises, held a full byte
	always @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			clk_prev_reg <= 1'b0;
			locked_reg <= 1'b0;
			tx_byte_out <= 8'h3a;
			frame_search_enable_out <= 1'b0;
		end else begin
			clk_prev_reg <= tx_byte_clock_in;
			if (tx_byte_clock_in && !clk_prev_reg)
				tx_byte_out <= tx_byte_out + 8'h4d;
			// one pulse confirms sync, so search drops until asked again
			if (!search_req_in)
				locked_reg <= 1'b0;
			else if (frame_found_pulse_in)
				locked_reg <= 1'b1;
			frame_search_enable_out <= search_req_in && !locked_reg && !frame_found_pulse_in;
		end
	end
endmodule
`default_nettype wire

/* File: sonet_align_pkg.sv */
// constants shared by the sonet byte align and serdes core
package sonet_align_pkg;
	localparam int BYTE_BITS = 8;
	localparam logic [2:0] BIT_CNT_LAST = 3'h7;
	localparam logic [2:0] BIT_CNT_HALF = 3'h4;
	// framing pattern, first received bit is the msb
	localparam logic [7:0] A1_BYTE = 8'hf6;
	localparam logic [7:0] A2_BYTE = 8'h28;
	localparam logic [47:0] FRAME_PATTERN = {A1_BYTE, A1_BYTE, A1_BYTE, A2_BYTE, A2_BYTE, A2_BYTE};
	// loss of signal detector, counts in bit periods
	localparam int LOS_WINDOW_BITS = 128;
	localparam logic [7:0] LOS_QUIET_BITS = 8'h80;
	localparam logic [7:0] LOS_CLEAR_TRANS = 8'h10;
	// byte clock periods in ps and serial rates in kbps
	localparam int HI_BYTE_PERIOD_PS = 12860;
	localparam int LO_BYTE_PERIOD_PS = 51440;
	localparam int HI_SERIAL_KBPS = 622080;
	localparam int LO_SERIAL_KBPS = 155520;
	// 64-bit product, the 32-bit one overflows; rounded to whole bits
	localparam int HI_BYTE_CYCLES = int'((longint'(HI_BYTE_PERIOD_PS) * HI_SERIAL_KBPS
		+ 64'd500000000) / 64'd1000000000);
	// register map, byte addresses
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] MATCH_COUNT_OFFSET = 8'h08;
	// control fields
	localparam int CTRL_SOFT_MUTE_BIT = 0;
	localparam int CTRL_RATE_HIGH_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h2;
	// status fields
	localparam int STAT_LOS_INT_BIT = 0;
	localparam int STAT_LOS_EFF_BIT = 1;
	localparam int STAT_SEARCH_BIT = 2;
	localparam int STAT_RATE_BIT = 3;
	localparam int STAT_PHASE_LSB = 4;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;
endpackage

/* File: sonet_byte_align_serdes_core.sv */
// receive framer search, deserializer, los mute, transmit serializer and ahb-lite registers
// What this block does
// - search the serial stream for three 0xf6 bytes then three 0x28 bytes
// - search runs while frame_search_enable is high, stops when it falls
// - found byte boundary groups serial bits into rx_byte_out[7:0]
// - frame_found_pulse marks the third a2 byte on a 48-bit match while searching
// - pulse lasts exactly one rx_byte_clock period per match while searching
// - after search ends the byte boundary stays fixed until a new search
// - high rate: 622.08 Mbps serial into bytes at 77.76 Mbps
// - low rate: 155.52 Mbps serial into bytes at 19.44 Mbps
// - consecutive serial bits are gathered into one 8-bit word
// - each new rx_byte_out value launches on the falling rx_byte_clock edge
// - rx_byte_clock runs at one eighth of the serial bit rate
// - loss of signal forces rx_byte_out to zero unless detection disabled, ext high
// - ext_signal_loss_n low forces loss of signal and mutes rx_byte_out
// - transmit serializes one bit per ref_clk_in cycle; the rate mode bit only shows in status
// - serial clock divided by eight drives tx_byte_clock to the framer
// - tx_byte_in is captured on each rising edge of tx_byte_clock
// - los set after over 128 quiet bits, cleared by 16 transitions in 128
// - internal_los_disable high keeps the internal detector from muting; it still runs and shows in status bit 0
// - serializer sends bit 7 first down to bit 0
`timescale 1ns/1ps
`default_nettype none
module sonet_byte_align_serdes_core (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic rx_serial_in,
	input wire logic frame_search_enable_in,
	input wire logic ext_signal_loss_n_in,
	input wire logic internal_los_disable_in,
	input wire logic [7:0] tx_byte_in,
	output logic [7:0] rx_byte_out,
	output logic rx_byte_clock_out,
	output logic frame_found_pulse_out,
	output logic tx_byte_clock_out,
	output logic tx_serial_out,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic [1:0] hresp_out
);
	localparam int WIN = sonet_align_pkg::LOS_WINDOW_BITS;

	////////////////////////////////////////////////////////////////////////////////
	// receive alignment and deserializer state
	logic [47:0] shift_reg, shift_next;
	logic [2:0] bit_cnt_reg, bit_cnt_next;
	logic [7:0] rx_byte_reg, rx_byte_next;
	logic rx_clk_reg, rx_clk_next;
	logic pulse_reg, pulse_next;
	logic [15:0] match_cnt_reg, match_cnt_next;
	logic [47:0] window;
	logic match;
	logic byte_done;
	logic los_eff;
	logic soft_mute;

	// window includes the bit arriving now, so a match is seen at any offset
	assign window = {shift_reg[46:0], rx_serial_in};
	assign match = frame_search_enable_in && (window == sonet_align_pkg::FRAME_PATTERN);
	assign byte_done = match || (bit_cnt_reg == sonet_align_pkg::BIT_CNT_LAST);

	// next state: a match restarts the byte phase, otherwise phase free-runs and stays put
	always_comb begin
		shift_next = window;
		bit_cnt_next = bit_cnt_reg + 3'h1;
		rx_byte_next = rx_byte_reg;
		pulse_next = pulse_reg;
		match_cnt_next = match_cnt_reg;
		if (match) begin
			bit_cnt_next = 3'h0;
			pulse_next = 1'b1;
			match_cnt_next = match_cnt_reg + 16'h0001;
		end else if (byte_done) begin
			pulse_next = 1'b0;
		end
		if (byte_done) begin
			// oldest of the eight bits sits at bit 7
			rx_byte_next = window[7:0];
			if (los_eff || soft_mute) begin
				rx_byte_next = 8'h00;
			end
		end
		// low for phases 0..3 so data changes as the clock falls
		rx_clk_next = (bit_cnt_next >= sonet_align_pkg::BIT_CNT_HALF);
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			shift_reg <= 48'h000000000000;
			bit_cnt_reg <= 3'h0;
			rx_byte_reg <= 8'h00;
			rx_clk_reg <= 1'b0;
			pulse_reg <= 1'b0;
			match_cnt_reg <= 16'h0000;
		end else begin
			shift_reg <= shift_next;
			bit_cnt_reg <= bit_cnt_next;
			rx_byte_reg <= rx_byte_next;
			rx_clk_reg <= rx_clk_next;
			pulse_reg <= pulse_next;
			match_cnt_reg <= match_cnt_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// internal loss of signal detector
	logic last_bit_reg, last_bit_next;
	logic [7:0] quiet_reg, quiet_next;
	logic [WIN-1:0] hist_reg, hist_next;
	logic [7:0] trans_cnt_reg, trans_cnt_next;
	logic los_int_reg, los_int_next;
	logic trans;

	assign trans = rx_serial_in ^ last_bit_reg;

	// sliding window costs 128 flops, cheaper than a per-bit timestamp scheme
	always_comb begin
		last_bit_next = rx_serial_in;
		hist_next = {hist_reg[WIN-2:0], trans};
		trans_cnt_next = trans_cnt_reg + {7'h00, trans} - {7'h00, hist_reg[WIN-1]};
		quiet_next = quiet_reg;
		los_int_next = los_int_reg;
		if (trans) begin
			quiet_next = 8'h00;
		end else if (quiet_reg != 8'hff) begin
			quiet_next = quiet_reg + 8'h01;
		end
		if (!trans && quiet_reg >= sonet_align_pkg::LOS_QUIET_BITS) begin
			los_int_next = 1'b1;
		end else if (los_int_reg && trans_cnt_next >= sonet_align_pkg::LOS_CLEAR_TRANS) begin
			los_int_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			last_bit_reg <= 1'b0;
			quiet_reg <= 8'h00;
			hist_reg <= '0;
			trans_cnt_reg <= 8'h00;
			los_int_reg <= 1'b0;
		end else begin
			last_bit_reg <= last_bit_next;
			quiet_reg <= quiet_next;
			hist_reg <= hist_next;
			trans_cnt_reg <= trans_cnt_next;
			los_int_reg <= los_int_next;
		end
	end

	// external loss always wins; the internal one only counts while enabled
	assign los_eff = (los_int_reg && !internal_los_disable_in) || !ext_signal_loss_n_in;

	////////////////////////////////////////////////////////////////////////////////
	// transmit byte clock divider and serializer
	logic [2:0] tx_cnt_reg, tx_cnt_next;
	logic tx_clk_reg, tx_clk_next;
	logic [7:0] tx_hold_reg, tx_hold_next;
	logic [7:0] tx_shift_reg, tx_shift_next;
	logic tx_ser_reg, tx_ser_next;

	// the reference clock stands in for the synthesized serial clock
	always_comb begin
		tx_cnt_next = tx_cnt_reg + 3'h1;
		tx_hold_next = tx_hold_reg;
		tx_shift_next = {tx_shift_reg[6:0], 1'b0};
		tx_ser_next = tx_shift_reg[6];
		if (tx_cnt_reg == sonet_align_pkg::BIT_CNT_LAST) begin
			tx_hold_next = tx_byte_in;
			tx_shift_next = tx_byte_in;
			tx_ser_next = tx_byte_in[7];
		end
		tx_clk_next = (tx_cnt_next < sonet_align_pkg::BIT_CNT_HALF);
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tx_cnt_reg <= sonet_align_pkg::BIT_CNT_LAST; // first edge wraps to 0, no short first period
			tx_clk_reg <= 1'b0;
			tx_hold_reg <= 8'h00;
			tx_shift_reg <= 8'h00;
			tx_ser_reg <= 1'b0;
		end else begin
			tx_cnt_reg <= tx_cnt_next;
			tx_clk_reg <= tx_clk_next;
			tx_hold_reg <= tx_hold_next;
			tx_shift_reg <= tx_shift_next;
			tx_ser_reg <= tx_ser_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// ahb-lite slave, zero wait states, always okay
	logic [1:0] ctrl_reg, ctrl_next;
	logic wr_pend_reg, wr_pend_next;
	logic [7:0] wr_addr_reg, wr_addr_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic hready_reg;
	logic [1:0] hresp_reg;
	logic addr_phase;
	logic [31:0] status_word;
	logic rate_high;

	assign soft_mute = ctrl_reg[sonet_align_pkg::CTRL_SOFT_MUTE_BIT];
	assign rate_high = ctrl_reg[sonet_align_pkg::CTRL_RATE_HIGH_BIT];
	assign addr_phase = hsel_in && hready_in && (htrans_in == sonet_align_pkg::HTRANS_NONSEQ);

	always_comb begin
		status_word = 32'h00000000;
		status_word[sonet_align_pkg::STAT_LOS_INT_BIT] = los_int_reg;
		status_word[sonet_align_pkg::STAT_LOS_EFF_BIT] = los_eff;
		status_word[sonet_align_pkg::STAT_SEARCH_BIT] = frame_search_enable_in;
		status_word[sonet_align_pkg::STAT_RATE_BIT] = rate_high;
		status_word[sonet_align_pkg::STAT_PHASE_LSB +: 3] = bit_cnt_reg;
	end

	// write data arrives a cycle after its address, so the address is held
	always_comb begin
		ctrl_next = ctrl_reg;
		wr_pend_next = addr_phase && hwrite_in;
		wr_addr_next = haddr_in[7:0];
		hrdata_next = hrdata_reg;
		if (wr_pend_reg && wr_addr_reg == sonet_align_pkg::CTRL_OFFSET) begin
			ctrl_next = hwdata_in[1:0];
		end
		if (addr_phase && !hwrite_in) begin
			case (haddr_in[7:0])
				sonet_align_pkg::CTRL_OFFSET: hrdata_next = {30'h0, ctrl_reg};
				sonet_align_pkg::STATUS_OFFSET: hrdata_next = status_word;
				sonet_align_pkg::MATCH_COUNT_OFFSET: hrdata_next = {16'h0000, match_cnt_reg};
				default: hrdata_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_reg <= sonet_align_pkg::CTRL_RESET;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata_reg <= 32'h00000000;
			hready_reg <= 1'b1;
			hresp_reg <= sonet_align_pkg::HRESP_OKAY;
		end else begin
			ctrl_reg <= ctrl_next;
			wr_pend_reg <= wr_pend_next;
			wr_addr_reg <= wr_addr_next;
			hrdata_reg <= hrdata_next;
			hready_reg <= 1'b1;
			hresp_reg <= sonet_align_pkg::HRESP_OKAY;
		end
	end

	assign rx_byte_out = rx_byte_reg;
	assign rx_byte_clock_out = rx_clk_reg;
	assign frame_found_pulse_out = pulse_reg;
	assign tx_byte_clock_out = tx_clk_reg;
	assign tx_serial_out = tx_ser_reg;
	assign hrdata_out = hrdata_reg;
	assign hreadyout_out = hready_reg;
	assign hresp_out = hresp_reg;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	chk_match_pulse: assert property (match |=> frame_found_pulse_out && bit_cnt_reg == 3'h0)
		else $error("match did not raise frame pulse");
	chk_pulse_width: assert property ($rose(frame_found_pulse_out) |->
		frame_found_pulse_out [*8] ##1 !frame_found_pulse_out)
		else $error("frame pulse not one byte clock long");
	chk_search_gate: assert property ($rose(frame_found_pulse_out) |-> $past(frame_search_enable_in))
		else $error("frame pulse without search enable");
	chk_boundary_hold: assert property (!frame_search_enable_in && byte_done
		##1 !frame_search_enable_in [*7] |=> byte_done)
		else $error("byte boundary moved while search off");
	chk_los_mute: assert property (los_eff && byte_done |=> rx_byte_out == 8'h00)
		else $error("rx byte not muted during loss of signal");
	chk_ext_mute: assert property (!ext_signal_loss_n_in && byte_done |=> rx_byte_out == 8'h00)
		else $error("external loss did not mute rx byte");
	chk_rx_launch: assert property ($changed(rx_byte_out) |-> !rx_byte_clock_out)
		else $error("rx byte changed while byte clock high");
	chk_rx_byte_bits: assert property (byte_done && !los_eff && !soft_mute |=>
		rx_byte_out == $past(window[7:0]))
		else $error("rx byte bit order wrong");
	chk_tx_divide: assert property ($rose(tx_byte_clock_out) |->
		tx_byte_clock_out [*4] ##1 !tx_byte_clock_out [*4] ##1 tx_byte_clock_out)
		else $error("tx byte clock not divide by eight");
	chk_tx_msb_first: assert property ($rose(tx_byte_clock_out) |->
		tx_serial_out == tx_hold_reg[7] ##1 tx_serial_out == tx_hold_reg[6]
		##6 tx_serial_out == tx_hold_reg[0])
		else $error("tx serial order wrong");
	chk_tx_capture: assert property ($rose(tx_byte_clock_out) |-> tx_hold_reg == $past(tx_byte_in))
		else $error("tx byte not captured at rising byte clock");
	chk_los_declare: assert property (quiet_reg == 8'h80 && !trans |=> los_int_reg)
		else $error("los not declared after quiet period");

	cov_frame_found: cover property (frame_search_enable_in ##1 match ##1 frame_found_pulse_out);
	cov_los_set: cover property ($rose(los_int_reg));
	cov_los_clear: cover property ($fell(los_int_reg));
	cov_ext_mute: cover property (!ext_signal_loss_n_in && byte_done);
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the sonet align and serdes core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic ref_clk_in, rst_in, rx_ser, ext_n, los_dis, search_req, search_en;
	logic [7:0] tx_byte, rx_byte, fill_byte, w;
	logic rx_clk, pulse, tx_clk, tx_ser, hsel, hwrite, hreadyout, p;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, hresp;
	int mismatches, compares, n;
	logic bits_q[$];
	initial begin
		ref_clk_in = 1'b0;
		forever #12.5 ref_clk_in = ~ref_clk_in;
	end
	sonet_byte_align_serdes_core uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.rx_serial_in(rx_ser), .frame_search_enable_in(search_en),
		.ext_signal_loss_n_in(ext_n), .internal_los_disable_in(los_dis),
		.tx_byte_in(tx_byte), .rx_byte_out(rx_byte), .rx_byte_clock_out(rx_clk),
		.frame_found_pulse_out(pulse), .tx_byte_clock_out(tx_clk), .tx_serial_out(tx_ser),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hreadyout), .hrdata_out(hrdata),
		.hreadyout_out(hreadyout), .hresp_out(hresp));
	framer_model fm (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .tx_byte_clock_in(tx_clk),
		.frame_found_pulse_in(pulse), .search_req_in(search_req), .tx_byte_out(tx_byte),
		.frame_search_enable_out(search_en));
	task push_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			bits_q.push_back(b[i]);
	endtask
	// serial source idles on fill_byte so the line never runs dry
	always @(posedge ref_clk_in) begin
		if (bits_q.size() == 0)
			push_byte(fill_byte);
		rx_ser <= bits_q.pop_front();
	end
	task stop_test;
		if (mismatches == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task cyc(input int c);
		repeat (c) @(posedge ref_clk_in);
	endtask
	// zero wait is not assumed: hready is polled under a bound
	task wait_ready;
		n = 0;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			mismatches++;
			stop_test();
		end
	endtask
	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		@(posedge ref_clk_in);
		hsel <= 1'b1;
		htrans <= sonet_align_pkg::HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= wr;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
		chk("hresp", 32'(hresp), 32'(sonet_align_pkg::HRESP_OKAY));
	endtask
	// pattern shifted three bits off the byte boundary of the bits already queued
	task push_frame;
		#1;
		bits_q.push_back(1'b1);
		bits_q.push_back(1'b0);
		bits_q.push_back(1'b1);
		repeat (3) push_byte(sonet_align_pkg::A1_BYTE);
		repeat (3) push_byte(sonet_align_pkg::A2_BYTE);
		push_byte(8'h3c);
	endtask
	initial begin
		{rst_in, ext_n, fill_byte} = {1'b1, 1'b1, 8'h55};
		{los_dis, search_req, hsel, hwrite, htrans, rx_ser} = '0;
		{haddr, hwdata, mismatches, compares} = '0;
		cyc(20);
		rst_in <= 1'b0;
		// control reset value, read-write control and an unmapped place
		ahb(1'b0, 32'(sonet_align_pkg::CTRL_OFFSET), 32'h0);
		chk("ctrl reset", rd, 32'(sonet_align_pkg::CTRL_RESET));
		ahb(1'b0, 32'h0c, 32'h0);
		chk("unmapped", rd, 32'h0);
		ahb(1'b1, 32'(sonet_align_pkg::CTRL_OFFSET), 32'h1);
		ahb(1'b0, 32'(sonet_align_pkg::CTRL_OFFSET), 32'h0);
		chk("ctrl rw", rd, 32'h1);
		cyc(20);
		chk("soft mute", 32'(rx_byte), 32'h0);
		// low rate selected above, status must show it
		ahb(1'b0, 32'(sonet_align_pkg::STATUS_OFFSET), 32'h0);
		chk("rate low", rd & 32'h8, 32'h0);
		ahb(1'b1, 32'(sonet_align_pkg::CTRL_OFFSET), 32'h2);
		// search finds the frame and realigns bytes
		search_req <= 1'b1;
		push_frame();
		n = 0;
		while (pulse !== 1'b1 && n < 200) begin
			@(posedge ref_clk_in);
			n++;
		end
		chk("pulse seen", 32'(pulse === 1'b1), 32'h1);
		for (int i = 0; i <= 8; i++) begin
			chk("pulse", 32'(pulse), 32'(i < 8));
			if (i == 0)
				chk("rx a2", 32'(rx_byte), 32'(sonet_align_pkg::A2_BYTE));
			if (i == 0)
				chk("rx clk low", 32'(rx_clk), 32'h0);
			if (i == 4)
				chk("rx clk high", 32'(rx_clk), 32'h1);
			if (i == 8)
				chk("rx byte", 32'(rx_byte), 32'h3c);
			@(posedge ref_clk_in);
		end
		ahb(1'b0, 32'(sonet_align_pkg::MATCH_COUNT_OFFSET), 32'h0);
		chk("matches", rd, 32'h1);
		// search off: a shifted pattern must neither pulse nor realign
		push_frame();
		for (int i = 0; i < 120; i++) begin
			@(posedge ref_clk_in);
			chk("held", 32'(pulse === 1'b1 || rx_byte === 8'h28), 32'h0);
		end
		// each word leaves msb first over one eighth-rate byte clock
		repeat (2) begin
			n = 0;
			do begin
				p = tx_clk;
				@(posedge ref_clk_in);
				n++;
			end while (!(tx_clk === 1'b1 && p === 1'b0) && n < 20);
			chk("tx rise", 32'(tx_clk === 1'b1 && p === 1'b0), 32'h1);
			w = tx_byte;
			for (int i = 0; i < 8; i++) begin
				chk("tx bit", 32'(tx_ser), 32'(w[7 - i]));
				chk("tx clk", 32'(tx_clk), 32'(i < 4));
				@(posedge ref_clk_in);
			end
		end
		// external loss mutes even with the detector off
		ext_n <= 1'b0;
		los_dis <= 1'b1;
		cyc(20);
		chk("ext mute", 32'(rx_byte), 32'h0);
		ahb(1'b0, 32'(sonet_align_pkg::STATUS_OFFSET), 32'h0);
		chk("ext los", rd & 32'h2, 32'h2);
		chk("rate high", rd & 32'h8, 32'h8);
		// stuck line sets the internal detector, toggling clears it
		ext_n <= 1'b1;
		los_dis <= 1'b0;
		fill_byte <= 8'hff;
		cyc(200);
		chk("quiet mute", 32'(rx_byte), 32'h0);
		ahb(1'b0, 32'(sonet_align_pkg::STATUS_OFFSET), 32'h0);
		chk("quiet los", rd & 32'h3, 32'h3);
		fill_byte <= 8'h55;
		cyc(150);
		ahb(1'b0, 32'(sonet_align_pkg::STATUS_OFFSET), 32'h0);
		chk("los clear", rd & 32'h1, 32'h0);
		chk("unmuted", 32'(rx_byte === 8'h00), 32'h0);
		// detector disabled: a stuck line passes through
		los_dis <= 1'b1;
		fill_byte <= 8'hff;
		cyc(200);
		chk("los off", 32'(rx_byte), 32'hff);
		stop_test();
	end
endmodule
`default_nettype wire
